/* File: rsdp_pkg.sv */
// Constants and types shared by the raw sample debug port
package rsdp_pkg;
  localparam int SAMPLE_W      = 12;
  localparam int LANES         = 4;
  localparam int EDGES_PER_SMP = SAMPLE_W / LANES;
  localparam int FRAME_EDGES   = 12;
  localparam int FRAME_HI      = FRAME_EDGES / 2;
  localparam int EDGE_W        = 4;

  // Aggregate rates in Mbps
  localparam int RATE_400_MBPS = 400;
  localparam int RATE_320_MBPS = 320;
  localparam int RATE_200_MBPS = 200;
  localparam int RATE_160_MBPS = 160;
  // Scaled timing: bit interval in CLK cycles is RATE_REF_MBPS / rate
  localparam int RATE_REF_MBPS = 1600;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] BIT_CYC_400 = CNT_W'(RATE_REF_MBPS / RATE_400_MBPS);
  localparam logic [CNT_W-1:0] BIT_CYC_320 = CNT_W'(RATE_REF_MBPS / RATE_320_MBPS);
  localparam logic [CNT_W-1:0] BIT_CYC_200 = CNT_W'(RATE_REF_MBPS / RATE_200_MBPS);
  localparam logic [CNT_W-1:0] BIT_CYC_160 = CNT_W'(RATE_REF_MBPS / RATE_160_MBPS);

  typedef enum logic [1:0] {
    RSDP_RATE_400 = 2'b00,
    RSDP_RATE_320 = 2'b01,
    RSDP_RATE_200 = 2'b10,
    RSDP_RATE_160 = 2'b11
  } rsdp_rate_t;

  typedef enum logic [0:0] {
    RSDP_IDLE  = 1'b0,
    RSDP_FRAME = 1'b1
  } rsdp_state_t;
endpackage : rsdp_pkg

/* File: rsdp_tick_if.sv */
// Carrier between the bit timer and the port core
`timescale 1ns/1ns
interface rsdp_tick_if;
  import rsdp_pkg::*;
  rsdp_rate_t rate;
  logic       tick;
  modport timer (input rate, output tick);
  modport core  (output rate, input tick);
endinterface : rsdp_tick_if

/* File: rsdp_bit_timer.sv */
// Bit interval divider: one tick per forwarded clock edge
`timescale 1ns/1ns
module rsdp_bit_timer
  import rsdp_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  rsdp_tick_if.timer  tk
);
  logic [CNT_W-1:0] cnt;

  function automatic logic [CNT_W-1:0] interval(input rsdp_rate_t r);
    case (r)
      RSDP_RATE_400: interval = BIT_CYC_400;
      RSDP_RATE_320: interval = BIT_CYC_320;
      RSDP_RATE_200: interval = BIT_CYC_200;
      default:       interval = BIT_CYC_160;
    endcase
  endfunction : interval

  // Free running, so the forwarded clock never pauses
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt     <= '0;
      tk.tick <= 1'b0;
    end else if (cnt >= interval(tk.rate) - CNT_W'(1)) begin
      cnt     <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt     <= cnt + CNT_W'(1);
      tk.tick <= 1'b0;
    end
  end
endmodule : rsdp_bit_timer

/* File: rsdp_port.sv */
// Transmit side of the raw sample debug port
`timescale 1ns/1ns
// Summary of operation
// - Outputs are four data lanes, a forwarded bit clock and a frame marker.
// - Aggregate rate is one of 400, 320, 200 or 160 Mbps.
// - A 12-bit sample goes out over four lanes in three edges, samples back to back.
// - A frame spans twelve bit clock edges, carrying forty-eight bits.
// - Frame marker may pause with idle gaps while no sample is pending.
// - Forwarded bit clock toggles continuously, gaps included.
// - Forwarded bit clock is derived from the block's own front-end clock.
// - A new frame's first bits launch on a rising bit clock edge.
// - Frame marker stays stable over each whole data bit interval.
module rsdp_port
  import rsdp_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire logic [1:0]          RATE_SEL,
  input  wire logic [SAMPLE_W-1:0] SAMPLE_DATA,
  input  wire logic                SAMPLE_VALID,
  output logic                     SAMPLE_READY,
  output logic [LANES-1:0]         DEBUG_DATA_LANE,
  output logic                     FORWARDED_BIT_CLOCK,
  output logic                     FRAME_MARKER_CLOCK
);
  rsdp_tick_if tk ();

  rsdp_state_t           state;
  logic [EDGE_W-1:0]     edge_cnt;
  logic [SAMPLE_W-1:0]   hold;
  logic                  hold_full;
  logic [SAMPLE_W-1:0]   shifter;
  logic [1:0]            piece;
  logic                  load_now;
  logic [SAMPLE_W-1:0]   next_shifter;
  logic                  frame_last;
  logic                  start_ok;
  logic                  opening;
  logic                  mid_frame;
  logic                  group_next;
  logic                  take;
  logic                  consume;
  logic                  next_marker;
  logic [LANES-1:0]      next_lanes;

  assign tk.rate = rsdp_rate_t'(RATE_SEL);

  rsdp_bit_timer u_timer (
    .clk   (CLK),
    .reset (RESET),
    .tk    (tk)
  );

  // Forwarded clock toggles on every tick, derived from CLK
  always_ff @(posedge CLK) begin
    if (RESET)
      FORWARDED_BIT_CLOCK <= 1'b0;
    else if (tk.tick)
      FORWARDED_BIT_CLOCK <= ~FORWARDED_BIT_CLOCK;
  end

  // Frames open only ahead of a rising bit clock edge
  function automatic logic may_open(input logic bclk_now,
                                    input logic word_held);
    may_open = !bclk_now && word_held;
  endfunction : may_open

  // Lane zero takes the top bit of the group
  function automatic logic [LANES-1:0] lane_map(input logic [SAMPLE_W-1:0] word);
    lane_map = '0;
    for (int i = 0; i < LANES; i++)
      lane_map[i] = word[SAMPLE_W-1-i];
  endfunction : lane_map

  // Twelfth edge already shown; the next tick either ends or reopens the frame
  assign frame_last = (state == RSDP_FRAME) && (edge_cnt == EDGE_W'(FRAME_EDGES));
  assign start_ok   = may_open(FORWARDED_BIT_CLOCK, hold_full);
  assign opening    = start_ok && (state == RSDP_IDLE || frame_last);
  assign mid_frame  = (state == RSDP_FRAME) && !frame_last;
  assign group_next = piece == 2'(0);

  // Frame state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= RSDP_IDLE;
    end else if (tk.tick) begin
      case (state)
        RSDP_IDLE: begin
          if (opening)
            state <= RSDP_FRAME;
        end
        RSDP_FRAME: begin
          // Twelfth edge falls, so a held word opens the next frame at once
          if (frame_last && !opening)
            state <= RSDP_IDLE;
        end
        default: begin
          state <= RSDP_IDLE;
        end
      endcase
    end
  end

  // Edges shown so far in this frame, one to twelve
  always_ff @(posedge CLK) begin
    if (RESET) begin
      edge_cnt <= '0;
    end else if (tk.tick) begin
      if (opening)
        edge_cnt <= EDGE_W'(1);
      else if (mid_frame)
        edge_cnt <= edge_cnt + EDGE_W'(1);
      else
        edge_cnt <= '0;
    end
  end

  // Position of the current sample inside its three-edge group
  always_ff @(posedge CLK) begin
    if (RESET) begin
      piece <= '0;
    end else if (tk.tick) begin
      if (opening)
        piece <= 2'(1);
      else if (mid_frame)
        piece <= (piece == 2'(EDGES_PER_SMP - 1)) ? '0 : piece + 2'(1);
      else
        piece <= '0;
    end
  end

  // A word leaves the hold at a frame's first edge and at each group boundary
  always_comb begin
    load_now = 1'b0;
    if (tk.tick) begin
      if (opening)
        load_now = 1'b1;
      else if (mid_frame)
        load_now = group_next;
    end
  end

  // High for edges one to six, low for seven to twelve and in gaps
  always_comb begin
    next_marker = 1'b0;
    if (opening)
      next_marker = 1'b1;
    else if (mid_frame)
      next_marker = edge_cnt < EDGE_W'(FRAME_HI);
  end

  // Missing sample mid-frame is padded with zero rather than stretching the frame
  always_comb begin
    next_shifter = shifter << LANES;
    if (load_now)
      next_shifter = hold_full ? hold : '0;
  end

  // Hold hand-off strobes
  assign take    = SAMPLE_VALID && SAMPLE_READY;
  assign consume = load_now && hold_full;

  // Single holding word, written only while it is empty
  always_ff @(posedge CLK) begin
    if (RESET)
      hold <= '0;
    else if (take)
      hold <= SAMPLE_DATA;
  end

  always_ff @(posedge CLK) begin
    if (RESET)
      hold_full <= 1'b0;
    else if (consume)
      hold_full <= 1'b0;
    else if (take)
      hold_full <= 1'b1;
  end

  // Registered ready reopens on the same edge that the hold empties
  always_ff @(posedge CLK) begin
    if (RESET)
      SAMPLE_READY <= 1'b0;
    else if (consume)
      SAMPLE_READY <= 1'b1;
    else if (take)
      SAMPLE_READY <= 1'b0;
    else
      SAMPLE_READY <= !hold_full;
  end

  // Lanes and marker change only with the bit clock, stable for the bit
  always_comb begin
    next_lanes = '0;
    if (opening || mid_frame)
      next_lanes = lane_map(next_shifter);
  end

  // Shifter cleared in gaps so a stale group cannot reappear
  always_ff @(posedge CLK) begin
    if (RESET)
      shifter <= '0;
    else if (tk.tick)
      shifter <= (opening || mid_frame) ? next_shifter : '0;
  end

  always_ff @(posedge CLK) begin
    if (RESET)
      DEBUG_DATA_LANE <= '0;
    else if (tk.tick)
      DEBUG_DATA_LANE <= next_lanes;
  end

  // Marker moves on the same tick as the lanes
  always_ff @(posedge CLK) begin
    if (RESET)
      FRAME_MARKER_CLOCK <= 1'b0;
    else if (tk.tick)
      FRAME_MARKER_CLOCK <= next_marker;
  end
endmodule : rsdp_port

/* File: rsdp_port_assertions.sv */
// Pin-level checks of the raw sample debug port
`timescale 1ns/1ns
module rsdp_port_assertions
  import rsdp_pkg::*;
(
  input wire logic             CLK,
  input wire logic             RESET,
  input wire logic [1:0]       RATE_SEL,
  input wire logic             SAMPLE_VALID,
  input wire logic             SAMPLE_READY,
  input wire logic [LANES-1:0] DEBUG_DATA_LANE,
  input wire logic             FORWARDED_BIT_CLOCK,
  input wire logic             FRAME_MARKER_CLOCK
);
  logic       pclk, chg;
  logic [1:0] prate;
  logic [3:0] cnt, fe;
  wire        tog = FORWARDED_BIT_CLOCK != pclk;
  wire        gap = fe == 4'h0 || fe == 4'hC;
  wire  [3:0] want = RATE_SEL == 2'h0 ? 4'h4 : RATE_SEL == 2'h1 ? 4'h5 : RATE_SEL == 2'h2 ? 4'h8 : 4'hA;
  always_ff @(posedge CLK) begin
    pclk  <= FORWARDED_BIT_CLOCK;
    prate <= RATE_SEL;
    cnt   <= (RESET || tog) ? 4'h1 : cnt + 4'h1;
    // Interval spanning a rate change has no defined length
    chg   <= RESET || RATE_SEL != prate || (chg && !tog);
    fe    <= RESET ? 4'h0 : !tog ? fe : gap ? {3'h0, FRAME_MARKER_CLOCK} : fe + 4'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence frame_start;
    $rose(FRAME_MARKER_CLOCK);
  endsequence
  AST_INTERVAL: assert property (tog && !chg && RATE_SEL == prate |-> cnt == want)
    else $error("bit interval length wrong");
  AST_CONT: assert property (cnt <= 4'hA)
    else $error("bit clock stopped");
  AST_STABLE: assert property (!tog |-> $stable(DEBUG_DATA_LANE) && $stable(FRAME_MARKER_CLOCK))
    else $error("lanes moved inside bit interval");
  AST_RISE: assert property (frame_start |-> FORWARDED_BIT_CLOCK)
    else $error("frame began on falling edge");
  AST_LOAD: assert property (frame_start |-> SAMPLE_READY)
    else $error("hold word not freed at frame start");
  AST_SHAPE: assert property (tog && !gap |-> FRAME_MARKER_CLOCK == (fe < 4'h6))
    else $error("frame marker shape wrong");
  AST_IDLE: assert property (tog && gap && !FRAME_MARKER_CLOCK |-> DEBUG_DATA_LANE == 4'h0)
    else $error("lanes busy in gap");
  AST_TAKE: assert property (SAMPLE_VALID && SAMPLE_READY |=> !SAMPLE_READY)
    else $error("ready kept after accept");
endmodule : rsdp_port_assertions
bind rsdp_port rsdp_port_assertions rsdp_port_assertions_inst (.*);

/* File: rsdp_capture_model.sv */
// Capture logic at the far end of the debug lanes
`timescale 1ns/1ns
module rsdp_capture_model
  import rsdp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [LANES-1:0] lanes,
  input  wire logic             bclk,
  input  wire logic             marker,
  output logic                  got,
  output logic [SAMPLE_W-1:0]   word
);
  logic       prev;
  logic [3:0] idx;
  // Lanes taken on each bit clock edge from a marker-high edge through the frame's twelfth; gap edges skipped
  always_ff @(posedge clk) begin
    prev <= bclk;
    got  <= 1'b0;
    if (reset) begin
      idx <= 4'h0;
    end else if (bclk != prev && (idx != 4'h0 || marker)) begin
      word <= {word[7:0], lanes[0], lanes[1], lanes[2], lanes[3]};
      got  <= idx % 4'h3 == 4'h2;
      idx  <= idx == 4'hB ? 4'h0 : idx + 4'h1;
    end
  end
endmodule : rsdp_capture_model

/* File: rsdp_port_tb_top.sv */
// Self-checking bench for the raw sample debug port
`timescale 1ns/1ns
module rsdp_port_tb_top
  import rsdp_pkg::*;
();
  logic                clk = 1'b0, reset = 1'b1, valid = 1'b0;
  logic [1:0]          rate = 2'h0;
  logic [SAMPLE_W-1:0] data = 12'h000, word, capq[$], expq[$];
  logic                ready, bclk, marker, got;
  logic [LANES-1:0]    lanes;
  int                  miscompares = 0, total_checks = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (got) capq.push_back(word);
  rsdp_port rsdp_port_inst (.CLK(clk), .RESET(reset), .RATE_SEL(rate), .SAMPLE_DATA(data), .SAMPLE_VALID(valid),
    .SAMPLE_READY(ready), .DEBUG_DATA_LANE(lanes), .FORWARDED_BIT_CLOCK(bclk), .FRAME_MARKER_CLOCK(marker));
  rsdp_capture_model rsdp_capture_model_inst (.clk(clk), .reset(reset), .lanes(lanes), .bclk(bclk),
    .marker(marker), .got(got), .word(word));
  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic fail(input string m);
    miscompares++;
    $display("unexpected %0t %s", $time, m);
  endtask : fail
  // Valid stays up between words so back-to-back offers never glitch
  task automatic send(input logic [SAMPLE_W-1:0] d);
    int n = 0;
    data  = d;
    valid = 1'b1;
    expq.push_back(d);
    while (ready !== 1'b1) begin
      @(negedge clk);
      if (++n > 500) begin
        fail("ready timeout");
        report_and_stop();
      end
    end
    @(negedge clk);
  endtask : send
  task automatic check_words();
    for (int n = 0; n < 3000 && capq.size() < expq.size(); n++) @(negedge clk);
    foreach (expq[i]) begin
      total_checks++;
      if (capq.size() <= i || capq[i] !== expq[i]) fail("captured word");
    end
    if (capq.size() < expq.size()) report_and_stop();
    capq.delete();
    expq.delete();
  endtask : check_words
  task automatic run_rates();
    for (int r = 0; r < 4; r++) begin
      rate = 2'(r);
      for (int i = 0; i < 4; i++) send(12'hA50 + 12'(r * 4 + i));
      valid = 1'b0;
      check_words();
    end
  endtask : run_rates
  task automatic back_to_back();
    rate = 2'h0;
    for (int i = 0; i < 8; i++) send(12'h3C0 ^ 12'(i * 291));
    valid = 1'b0;
    check_words();
  endtask : back_to_back
  // Lone word: the three empty slots of its frame go out as zeros
  task automatic short_frame();
    send(12'hF81);
    valid = 1'b0;
    repeat (3) expq.push_back(12'h000);
    check_words();
  endtask : short_frame
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    run_rates();
    back_to_back();
    short_frame();
    report_and_stop();
  end
endmodule : rsdp_port_tb_top
